// ---- epd_cmd_pkg.sv ----
// constants, codes and field layouts shared by the command decoder and its receiver
package epd_cmd_pkg;

	// command codes
	localparam logic [7:0] CMD_BORDER = 8'h3C;
	localparam logic [7:0] CMD_END_OPTION = 8'h3F;
	localparam logic [7:0] CMD_READ_SELECT = 8'h41;
	localparam logic [7:0] CMD_X_WINDOW = 8'h44;
	localparam logic [7:0] CMD_Y_WINDOW = 8'h45;
	localparam logic [7:0] CMD_FILL_RED = 8'h46;
	localparam logic [7:0] CMD_FILL_MONO = 8'h47;
	localparam logic [7:0] CMD_X_COUNTER = 8'h4E;
	localparam logic [7:0] CMD_Y_COUNTER = 8'h4F;
	localparam logic [7:0] CMD_NO_OPERATION = 8'h7F;
	localparam logic [7:0] CMD_WRITE_MONO = 8'h24;
	localparam logic [7:0] CMD_WRITE_RED = 8'h26;

	// power-on values and end option codes
	localparam logic [7:0] BORDER_RST = 8'hC0;
	localparam logic [7:0] END_OPTION_RST = 8'h02;
	localparam logic [7:0] END_OPTION_NORMAL = 8'h22;
	localparam logic [7:0] END_OPTION_HOLD = 8'h07;
	localparam logic READ_SELECT_RST = 1'b0;
	localparam logic [5:0] X_START_RST = 6'h00;
	localparam logic [5:0] X_END_RST = 6'h15;
	localparam logic [8:0] Y_START_RST = 9'h000;
	localparam logic [8:0] Y_END_RST = 9'h127;
	localparam logic [7:0] FILL_RST = 8'h00;
	localparam logic [5:0] X_COUNTER_RST = 6'h00;
	localparam logic [8:0] Y_COUNTER_RST = 9'h000;

	// field positions
	localparam int BORDER_OPT_LSB = 6;
	localparam int BORDER_LEVEL_LSB = 4;
	localparam int BORDER_FULL_BIT = 2;
	localparam int BORDER_LUT_LSB = 0;
	localparam int FILL_FIRST_BIT = 7;
	localparam int FILL_HEIGHT_LSB = 4;
	localparam int FILL_WIDTH_LSB = 0;
	localparam logic [7:0] BORDER_DEFINED_MASK = 8'hF7;
	localparam logic [7:0] FILL_DEFINED_MASK = 8'hF7;

	// fill walks the whole memory: 22 bytes across, 296 gate rows
	localparam logic [5:0] FILL_X_LAST = 6'h15;
	localparam logic [8:0] FILL_Y_LAST = 9'h127;

	// pin vector order and idle levels (chip select idles high)
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_CS_N = 2;
	localparam int PIN_DC = 3;
	localparam logic [3:0] PIN_IDLE = 4'h4;

	typedef enum logic [1:0] {
		BORDER_TRANSITION = 2'b00,
		BORDER_FIXED = 2'b01,
		BORDER_VCOM = 2'b10,
		BORDER_HIZ = 2'b11
	} border_mode_t;

	typedef enum logic [1:0] {
		LEVEL_GROUND = 2'b00,
		LEVEL_POS_ONE = 2'b01,
		LEVEL_NEG = 2'b10,
		LEVEL_POS_TWO = 2'b11
	} border_level_t;

	typedef enum logic [1:0] {
		FILL_IDLE = 2'b00,
		FILL_RUN = 2'b01,
		FILL_DONE = 2'b10
	} fill_state_t;

	// step height in gate rows; zero marks a reserved code
	function automatic logic [8:0] step_rows(input logic [2:0] code);
		case (code)
			3'h0: step_rows = 9'h008;
			3'h1: step_rows = 9'h010;
			3'h2: step_rows = 9'h020;
			3'h3: step_rows = 9'h040;
			3'h4: step_rows = 9'h080;
			3'h5: step_rows = 9'h100;
			3'h6: step_rows = 9'h128;
			default: step_rows = 9'h000;
		endcase
	endfunction : step_rows

	// step width in bytes of eight sources; zero marks a reserved code
	function automatic logic [4:0] step_bytes(input logic [2:0] code);
		case (code)
			3'h0: step_bytes = 5'h01;
			3'h1: step_bytes = 5'h02;
			3'h2: step_bytes = 5'h04;
			3'h3: step_bytes = 5'h08;
			3'h4: step_bytes = 5'h10;
			3'h5: step_bytes = 5'h16;
			default: step_bytes = 5'h00;
		endcase
	endfunction : step_bytes

endpackage : epd_cmd_pkg

// ---- spi_byte_receiver.sv ----
// serial pin synchroniser and byte assembler for command and parameter bytes
`timescale 1ns/1ps
module spi_byte_receiver import epd_cmd_pkg::*; (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic core_ce,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic chip_select_n,
	input wire logic data_command_sel,
	output logic byte_valid_ff,
	output logic [7:0] byte_data_ff,
	output logic byte_is_cmd_ff
);
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic [3:0] sync3_ff;
	logic [3:0] level_ff;
	logic [3:0] agree;
	logic [3:0] nxt_level;
	logic [6:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic sclk_rise;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_ff <= PIN_IDLE;
			sync2_ff <= PIN_IDLE;
			sync3_ff <= PIN_IDLE;
			level_ff <= PIN_IDLE;
		end else if (core_ce) begin
			sync1_ff <= {data_command_sel, chip_select_n, serial_data, serial_clk};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			level_ff <= nxt_level;
		end
	end

	// a pin level is accepted only once two later stages agree, filtering glitches
	assign agree = ~(sync2_ff ^ sync3_ff);
	assign nxt_level = (agree & sync3_ff) | (~agree & level_ff);
	assign sclk_rise = nxt_level[PIN_SCLK] & ~level_ff[PIN_SCLK];

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_ff <= 7'h00;
			bit_cnt_ff <= 3'h0;
			byte_valid_ff <= 1'b0;
			byte_data_ff <= 8'h00;
			byte_is_cmd_ff <= 1'b0;
		end else if (core_ce) begin
			byte_valid_ff <= 1'b0;
			if (nxt_level[PIN_CS_N]) begin
				bit_cnt_ff <= 3'h0;
			end else if (sclk_rise) begin
				shift_ff <= {shift_ff[5:0], nxt_level[PIN_SDATA]};
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
				if (bit_cnt_ff == 3'h7) begin
					byte_valid_ff <= 1'b1;
					byte_data_ff <= {shift_ff, nxt_level[PIN_SDATA]};
					byte_is_cmd_ff <= ~nxt_level[PIN_DC];
				end
			end
		end
	end
endmodule : spi_byte_receiver

// ---- epd_ram_window_command_set.sv ----
// command decoder: border, end option, read select, RAM window, counters and pattern fill
// How it works
// - border bits 7:6 pick transition, fixed, vcom or hi-z; power-on C0h
// - fixed mode: bits 5:4 pick ground, source one, negative, source two
// - transition mode bit 2: 0 gives vcom on red, 1 follows table fully
// - transition mode bits 1:0 pick waveform table 0 to 3
// - command 3F stores one end option byte; power-on 02h, 22h is normal
// - end option 07h holds source levels from before power-off
// - command 41 bit 0 picks readback memory; 0 mono, 1 red
// - command 44 takes 6-bit x window start and end; power-on 00h, 15h
// - command 45 takes 9-bit y start and end, low byte first; 000h, 127h
// - command 46 fills red memory; bit 7 first value, bits 6:4 step height
// - fill bits 2:0 give step width 8 to 176; codes 6 and 7 invalid
// - busy stays high through the whole fill; host waits for low
// - command 47 does the same fill on the mono memory; power-on 00h
// - command 4E loads 6-bit x address counter; power-on 00h
// - command 4F loads 9-bit y address counter, low byte first; 000h
// - command 7F does nothing but ends any memory write sequence
`timescale 1ns/1ps
module epd_ram_window_command_set import epd_cmd_pkg::*; (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic core_ce,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic chip_select_n,
	input wire logic data_command_sel,
	output logic busy_ff,
	output border_mode_t border_mode_ff,
	output border_level_t border_level_ff,
	output logic border_red_vcom_ff,
	output logic [1:0] border_table_ff,
	output logic [7:0] waveform_end_option_ff,
	output logic source_hold_at_end_ff,
	output logic end_normal_ff,
	output logic readback_red_ff,
	output logic [5:0] x_window_start_ff,
	output logic [5:0] x_window_end_ff,
	output logic [8:0] y_window_start_ff,
	output logic [8:0] y_window_end_ff,
	output logic [5:0] ram_address_counter_x_ff,
	output logic [8:0] ram_address_counter_y_ff,
	output logic mem_seq_active_ff,
	output logic ram_wr_ff,
	output logic ram_red_ff,
	output logic [5:0] ram_addr_x_ff,
	output logic [8:0] ram_addr_y_ff,
	output logic [7:0] ram_data_ff
);
	logic byte_valid;
	logic [7:0] byte_data;
	logic byte_is_cmd;
	logic [7:0] cmd_ff;
	logic [2:0] param_idx_ff;
	logic [7:0] red_pattern_fill_ff;
	logic [7:0] mono_pattern_fill_ff;
	logic param_wr;
	logic cmd_wr;
	logic fill_cmd;
	logic fill_start;
	fill_state_t fill_state_ff;
	logic [8:0] fill_rows_ff;
	logic [4:0] fill_bytes_ff;
	logic fill_first_ff;
	logic [5:0] fx_ff;
	logic [8:0] fy_ff;
	logic [4:0] xph_ff;
	logic [8:0] yph_ff;
	logic xval_ff;
	logic yval_ff;

	spi_byte_receiver u_rx (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.core_ce(core_ce),
		.serial_clk(serial_clk),
		.serial_data(serial_data),
		.chip_select_n(chip_select_n),
		.data_command_sel(data_command_sel),
		.byte_valid_ff(byte_valid),
		.byte_data_ff(byte_data),
		.byte_is_cmd_ff(byte_is_cmd)
	);

	// bytes arriving during a fill are dropped; the host must watch busy
	assign cmd_wr = core_ce && byte_valid && byte_is_cmd && !busy_ff;
	assign param_wr = core_ce && byte_valid && !byte_is_cmd && !busy_ff;
	assign fill_cmd = (cmd_ff == CMD_FILL_RED) || (cmd_ff == CMD_FILL_MONO);
	assign fill_start = param_wr && fill_cmd && (param_idx_ff == 3'h0)
		&& (step_rows(byte_data[FILL_HEIGHT_LSB +: 3]) != 9'h000)
		&& (step_bytes(byte_data[FILL_WIDTH_LSB +: 3]) != 5'h00);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_ff <= CMD_NO_OPERATION;
			param_idx_ff <= 3'h0;
		end else if (cmd_wr) begin
			cmd_ff <= byte_data;
			param_idx_ff <= 3'h0;
		end else if (param_wr && param_idx_ff != 3'h7) begin
			param_idx_ff <= param_idx_ff + 3'h1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			border_mode_ff <= border_mode_t'(BORDER_RST[BORDER_OPT_LSB +: 2]);
			border_level_ff <= border_level_t'(BORDER_RST[BORDER_LEVEL_LSB +: 2]);
			border_red_vcom_ff <= ~BORDER_RST[BORDER_FULL_BIT];
			border_table_ff <= BORDER_RST[BORDER_LUT_LSB +: 2];
		end else if (param_wr && cmd_ff == CMD_BORDER && param_idx_ff == 3'h0) begin
			border_mode_ff <= border_mode_t'(byte_data[BORDER_OPT_LSB +: 2]);
			border_level_ff <= border_level_t'(byte_data[BORDER_LEVEL_LSB +: 2]);
			border_red_vcom_ff <= ~byte_data[BORDER_FULL_BIT];
			border_table_ff <= byte_data[BORDER_LUT_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			waveform_end_option_ff <= END_OPTION_RST;
			source_hold_at_end_ff <= (END_OPTION_RST == END_OPTION_HOLD);
			end_normal_ff <= (END_OPTION_RST == END_OPTION_NORMAL);
		end else if (param_wr && cmd_ff == CMD_END_OPTION && param_idx_ff == 3'h0) begin
			waveform_end_option_ff <= byte_data;
			source_hold_at_end_ff <= (byte_data == END_OPTION_HOLD);
			end_normal_ff <= (byte_data == END_OPTION_NORMAL);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			readback_red_ff <= READ_SELECT_RST;
		end else if (param_wr && cmd_ff == CMD_READ_SELECT && param_idx_ff == 3'h0) begin
			readback_red_ff <= byte_data[0];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			x_window_start_ff <= X_START_RST;
			x_window_end_ff <= X_END_RST;
		end else if (param_wr && cmd_ff == CMD_X_WINDOW) begin
			case (param_idx_ff)
				3'h0: x_window_start_ff <= byte_data[5:0];
				3'h1: x_window_end_ff <= byte_data[5:0];
				default: ;
			endcase
		end
	end

	// each byte lands directly; a half-written bound is visible until its pair arrives
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			y_window_start_ff <= Y_START_RST;
			y_window_end_ff <= Y_END_RST;
		end else if (param_wr && cmd_ff == CMD_Y_WINDOW) begin
			case (param_idx_ff)
				3'h0: y_window_start_ff[7:0] <= byte_data;
				3'h1: y_window_start_ff[8] <= byte_data[0];
				3'h2: y_window_end_ff[7:0] <= byte_data;
				3'h3: y_window_end_ff[8] <= byte_data[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ram_address_counter_x_ff <= X_COUNTER_RST;
			ram_address_counter_y_ff <= Y_COUNTER_RST;
		end else if (param_wr && cmd_ff == CMD_X_COUNTER && param_idx_ff == 3'h0) begin
			ram_address_counter_x_ff <= byte_data[5:0];
		end else if (param_wr && cmd_ff == CMD_Y_COUNTER) begin
			case (param_idx_ff)
				3'h0: ram_address_counter_y_ff[7:0] <= byte_data;
				3'h1: ram_address_counter_y_ff[8] <= byte_data[0];
				default: ;
			endcase
		end
	end

	// any command other than a memory write opens no sequence, so it also closes one
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mem_seq_active_ff <= 1'b0;
		end else if (cmd_wr) begin
			mem_seq_active_ff <= (byte_data == CMD_WRITE_MONO)
				|| (byte_data == CMD_WRITE_RED);
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			red_pattern_fill_ff <= FILL_RST;
			mono_pattern_fill_ff <= FILL_RST;
		end else if (param_wr && param_idx_ff == 3'h0) begin
			if (cmd_ff == CMD_FILL_RED)
				red_pattern_fill_ff <= byte_data & FILL_DEFINED_MASK;
			if (cmd_ff == CMD_FILL_MONO)
				mono_pattern_fill_ff <= byte_data & FILL_DEFINED_MASK;
		end
	end

	// fill walks the full memory row by row, one byte of eight sources per cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fill_state_ff <= FILL_IDLE;
			busy_ff <= 1'b0;
			fill_rows_ff <= 9'h000;
			fill_bytes_ff <= 5'h00;
			fill_first_ff <= 1'b0;
			ram_red_ff <= 1'b0;
			fx_ff <= 6'h00;
			fy_ff <= 9'h000;
			xph_ff <= 5'h00;
			yph_ff <= 9'h000;
			xval_ff <= 1'b0;
			yval_ff <= 1'b0;
			ram_wr_ff <= 1'b0;
			ram_addr_x_ff <= 6'h00;
			ram_addr_y_ff <= 9'h000;
			ram_data_ff <= 8'h00;
		end else if (core_ce) begin
			case (fill_state_ff)
				FILL_IDLE: begin
					ram_wr_ff <= 1'b0;
					if (fill_start) begin
						fill_state_ff <= FILL_RUN;
						busy_ff <= 1'b1;
						fill_rows_ff <= step_rows(byte_data[FILL_HEIGHT_LSB +: 3]);
						fill_bytes_ff <= step_bytes(byte_data[FILL_WIDTH_LSB +: 3]);
						fill_first_ff <= byte_data[FILL_FIRST_BIT];
						ram_red_ff <= (cmd_ff == CMD_FILL_RED);
						fx_ff <= 6'h00;
						fy_ff <= 9'h000;
						xph_ff <= 5'h00;
						yph_ff <= 9'h000;
						xval_ff <= 1'b0;
						yval_ff <= 1'b0;
					end
				end
				FILL_RUN: begin
					ram_wr_ff <= 1'b1;
					ram_addr_x_ff <= fx_ff;
					ram_addr_y_ff <= fy_ff;
					ram_data_ff <= {8{fill_first_ff ^ xval_ff ^ yval_ff}};
					if (fx_ff == FILL_X_LAST) begin
						fx_ff <= 6'h00;
						xph_ff <= 5'h00;
						xval_ff <= 1'b0;
						if (fy_ff == FILL_Y_LAST) begin
							fill_state_ff <= FILL_DONE;
						end else begin
							fy_ff <= fy_ff + 9'h001;
							if (yph_ff == fill_rows_ff - 9'h001) begin
								yph_ff <= 9'h000;
								yval_ff <= ~yval_ff;
							end else begin
								yph_ff <= yph_ff + 9'h001;
							end
						end
					end else begin
						fx_ff <= fx_ff + 6'h01;
						if (xph_ff == fill_bytes_ff - 5'h01) begin
							xph_ff <= 5'h00;
							xval_ff <= ~xval_ff;
						end else begin
							xph_ff <= xph_ff + 5'h01;
						end
					end
				end
				FILL_DONE: begin
					// busy drops with the last write strobe, never before it
					ram_wr_ff <= 1'b0;
					busy_ff <= 1'b0;
					fill_state_ff <= FILL_IDLE;
				end
				default: begin
					fill_state_ff <= FILL_IDLE;
					busy_ff <= 1'b0;
					ram_wr_ff <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	property p_border_write;
		param_wr && cmd_ff == CMD_BORDER && param_idx_ff == 3'h0 |=>
			border_mode_ff == $past(byte_data[7:6]) && border_level_ff == $past(byte_data[5:4])
			&& border_red_vcom_ff == !$past(byte_data[2]) && border_table_ff == $past(byte_data[1:0]);
	endproperty
	a_border_write: assert property (p_border_write) else $error("border fields wrong");

	property p_end_hold;
		source_hold_at_end_ff == (waveform_end_option_ff == END_OPTION_HOLD);
	endproperty
	a_end_hold: assert property (p_end_hold) else $error("source hold mismatch");

	property p_end_write;
		param_wr && cmd_ff == CMD_END_OPTION && param_idx_ff == 3'h0 |=>
			waveform_end_option_ff == $past(byte_data);
	endproperty
	a_end_write: assert property (p_end_write) else $error("end option not stored");

	property p_extra_ignored;
		param_wr && cmd_ff == CMD_END_OPTION && param_idx_ff != 3'h0 |=>
			$stable(waveform_end_option_ff);
	endproperty
	a_extra_ignored: assert property (p_extra_ignored) else $error("extra byte stored");

	property p_read_select;
		param_wr && cmd_ff == CMD_READ_SELECT && param_idx_ff == 3'h0 |=>
			readback_red_ff == $past(byte_data[0]);
	endproperty
	a_read_select: assert property (p_read_select) else $error("read select wrong");

	property p_y_high;
		param_wr && cmd_ff == CMD_Y_WINDOW && param_idx_ff == 3'h3 |=>
			y_window_end_ff[8] == $past(byte_data[0]) && $stable(y_window_start_ff);
	endproperty
	a_y_high: assert property (p_y_high) else $error("y end bit 8 wrong");

	property p_x_counter;
		param_wr && cmd_ff == CMD_X_COUNTER && param_idx_ff == 3'h0 |=>
			ram_address_counter_x_ff == $past(byte_data[5:0]);
	endproperty
	a_x_counter: assert property (p_x_counter) else $error("x counter not loaded");

	property p_fill_busy;
		fill_start |=> busy_ff ##1 (busy_ff && ram_wr_ff) [*8];
	endproperty
	a_fill_busy: assert property (p_fill_busy) else $error("busy low during fill");

	property p_fill_invalid;
		param_wr && fill_cmd && param_idx_ff == 3'h0 && byte_data[2:1] == 2'b11 |=> !busy_ff;
	endproperty
	a_fill_invalid: assert property (p_fill_invalid) else $error("invalid fill ran");

	property p_busy_end;
		$fell(busy_ff) |-> $past(ram_addr_x_ff) == FILL_X_LAST
			&& $past(ram_addr_y_ff) == FILL_Y_LAST && !ram_wr_ff;
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy fell early");

	property p_nop_ends;
		cmd_wr && byte_data == CMD_NO_OPERATION |=> !mem_seq_active_ff;
	endproperty
	a_nop_ends: assert property (p_nop_ends) else $error("nop left sequence open");

	c_fill_red: cover property (fill_start && cmd_ff == CMD_FILL_RED);
	c_fill_done: cover property ($fell(busy_ff));
	c_nop_close: cover property (mem_seq_active_ff ##1 !mem_seq_active_ff);
	c_border_fixed: cover property (border_mode_ff == BORDER_FIXED);
endmodule : epd_ram_window_command_set

// ---- spi_host_model.sv ----
// host controller model driving the serial command pins of the decoder
`timescale 1ns/1ps
module spi_host_model #(
	parameter int INIT_WAIT_CYCLES = 200
) (
	input wire logic core_clk,
	output logic serial_clk,
	output logic serial_data,
	output logic chip_select_n,
	output logic data_command_sel
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		chip_select_n = 1'b1;
		data_command_sel = 1'b0;
	end

	// four core cycles per half period keeps clear of the synchroniser
	task automatic half_period();
		repeat (4) @(negedge core_clk);
	endtask : half_period

	task automatic send_byte(input logic dc, input logic [7:0] value);
		data_command_sel = dc;
		for (int i = 7; i >= 0; i--) begin
			serial_data = value[i];
			half_period();
			serial_clk = 1'b1;
			half_period();
			serial_clk = 1'b0;
		end
	endtask : send_byte

	// params go out lowest byte first; clock stays low outside the frame
	task automatic send_cmd(input logic [7:0] cmd, input int n, input logic [31:0] params);
		@(negedge core_clk);
		chip_select_n = 1'b0;
		send_byte(1'b0, cmd);
		for (int k = 0; k < n; k++) begin
			send_byte(1'b1, params[8*k +: 8]);
		end
		@(negedge core_clk);
		chip_select_n = 1'b1;
		serial_data = ~serial_data;
		repeat (12) @(negedge core_clk);
	endtask : send_cmd

	// wait after software reset is shortened; the decoder does not time it
	task automatic init_sequence();
		send_cmd(8'h12, 0, 32'h0000_0000);
		repeat (INIT_WAIT_CYCLES) @(negedge core_clk);
		send_cmd(8'h01, 3, 32'h0000_00F9);
		send_cmd(8'h11, 1, 32'h0000_0001);
		send_cmd(8'h44, 2, 32'h0000_1001);
		send_cmd(8'h45, 4, 32'h0000_00F9);
		send_cmd(8'h3C, 1, 32'h0000_00C0);
	endtask : init_sequence
endmodule : spi_host_model

// ---- tb.sv ----
// self-checking bench for the command decoder with a serial host model
`timescale 1ns/1ps
module tb import epd_cmd_pkg::*;;
	logic core_clk, reset_n, serial_clk, serial_data, chip_select_n, data_command_sel, busy_ff;
	border_mode_t border_mode_ff;
	border_level_t border_level_ff;
	logic border_red_vcom_ff, source_hold_at_end_ff, end_normal_ff, readback_red_ff;
	logic mem_seq_active_ff, ram_wr_ff, ram_red_ff;
	logic [1:0] border_table_ff;
	logic [7:0] waveform_end_option_ff, ram_data_ff, fill_param, p;
	logic [5:0] x_window_start_ff, x_window_end_ff, ram_address_counter_x_ff, ram_addr_x_ff;
	logic [8:0] y_window_start_ff, y_window_end_ff, ram_address_counter_y_ff, ram_addr_y_ff;
	logic [31:0] r;
	logic fill_to_red, busy_seen, core_ce;
	int checks, miscompares, fill_x, fill_y, fill_writes;

	epd_ram_window_command_set dut (.core_clk, .reset_n, .core_ce, .serial_clk,
		.serial_data, .chip_select_n, .data_command_sel, .busy_ff, .border_mode_ff,
		.border_level_ff, .border_red_vcom_ff, .border_table_ff, .waveform_end_option_ff,
		.source_hold_at_end_ff, .end_normal_ff, .readback_red_ff, .x_window_start_ff,
		.x_window_end_ff, .y_window_start_ff, .y_window_end_ff, .ram_address_counter_x_ff,
		.ram_address_counter_y_ff, .mem_seq_active_ff, .ram_wr_ff, .ram_red_ff,
		.ram_addr_x_ff, .ram_addr_y_ff, .ram_data_ff);

	spi_host_model host (.core_clk, .serial_clk, .serial_data, .chip_select_n,
		.data_command_sel);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic check(input logic ok, input string what);
		checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : check

	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// expected fill byte from step sizes in bytes and rows
	function automatic logic [7:0] fill_byte(input logic [7:0] pv, input int x, input int y);
		int w;
		int h;
		logic b;
		w = (pv[2:0] == 3'h5) ? 22 : (1 << pv[2:0]);
		h = (pv[6:4] == 3'h6) ? 296 : (8 << pv[6:4]);
		b = pv[7] ^ (((x / w) % 2) != 0) ^ (((y / h) % 2) != 0);
		return {8{b}};
	endfunction : fill_byte

	// sampled half a cycle after launch so every strobe is seen once, settled
	always @(negedge core_clk) begin
		if (busy_ff === 1'b1) busy_seen = 1'b1;
		if (ram_wr_ff === 1'b1) begin
			check(busy_ff === 1'b1 && ram_red_ff === fill_to_red, "fill busy/target");
			check(ram_addr_x_ff === 6'(fill_x) && ram_addr_y_ff === 9'(fill_y)
				&& ram_data_ff === fill_byte(fill_param, fill_x, fill_y), "fill byte");
			fill_writes++;
			if (fill_x == 21) begin
				fill_x = 0;
				fill_y++;
			end else fill_x++;
		end
	end

	task automatic run_fill(input logic [7:0] cmd, input logic [7:0] pv, input bit valid);
		fill_param = pv;
		fill_to_red = (cmd == CMD_FILL_RED);
		fill_x = 0;
		fill_y = 0;
		fill_writes = 0;
		busy_seen = 1'b0;
		host.send_cmd(cmd, 1, {24'h00_0000, pv});
		for (int i = 0; i < 8000 && busy_ff === 1'b1; i++) @(negedge core_clk);
		check(busy_ff === 1'b0 && busy_seen === valid, "fill busy span");
		check(fill_writes == (valid ? 6512 : 0), "fill write count");
	endtask : run_fill

	initial begin
		#(60_000 * 8);
		miscompares++;
		complete_run();
	end

	initial begin
		reset_n = 1'b0;
		core_ce = 1'b1;
		void'($urandom(32'h0000_804C));
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		check(border_mode_ff === BORDER_HIZ && border_table_ff === 2'h0, "border reset");
		check(waveform_end_option_ff === 8'h02 && end_normal_ff === 1'b0, "end reset");
		check(readback_red_ff === 1'b0 && busy_ff === 1'b0, "readback reset");
		check(x_window_start_ff === 6'h00 && x_window_end_ff === 6'h15, "x reset");
		check(y_window_start_ff === 9'h000 && y_window_end_ff === 9'h127, "y reset");
		check(ram_address_counter_x_ff === 6'h00, "x counter reset");
		check(ram_address_counter_y_ff === 9'h000, "y counter reset");
		host.init_sequence();
		check(x_window_start_ff === 6'h01 && x_window_end_ff === 6'h10, "init x");
		check(y_window_start_ff === 9'h0F9 && y_window_end_ff === 9'h000, "init y");
		check(border_mode_ff === BORDER_HIZ, "init border");
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			p = {2'(i % 4), 2'(i / 2), r[3:0]};
			host.send_cmd(CMD_BORDER, 1, r[31:8] << 8 | 32'(p));
			check(border_mode_ff === border_mode_t'(p[7:6]), "border mode");
			check(border_level_ff === border_level_t'(p[5:4]), "border level");
			check(border_red_vcom_ff === ~p[2], "border red");
			check(border_table_ff === p[1:0], "border table");
		end
		for (int i = 0; i < 3; i++) begin
			p = (i == 0) ? 8'h22 : (i == 1) ? 8'h07 : 8'($urandom);
			host.send_cmd(CMD_END_OPTION, 2, {16'h0000, 8'($urandom), p});
			check(waveform_end_option_ff === p && end_normal_ff === (p == 8'h22), "end");
			check(source_hold_at_end_ff === (p == 8'h07), "end hold");
		end
		for (int i = 0; i < 2; i++) begin
			p = {7'($urandom), i[0]};
			host.send_cmd(CMD_READ_SELECT, 1, 32'(p));
			check(readback_red_ff === i[0], "readback select");
		end
		// enable low freezes the pin synchroniser too, so the whole frame is lost
		core_ce = 1'b0;
		host.send_cmd(CMD_READ_SELECT, 1, 32'h0000_0000);
		core_ce = 1'b1;
		check(readback_red_ff === 1'b1, "frozen while disabled");
		r = $urandom;
		host.send_cmd(CMD_X_WINDOW, 3, r);
		check(x_window_start_ff === r[5:0] && x_window_end_ff === r[13:8], "x win");
		r = $urandom;
		host.send_cmd(CMD_Y_WINDOW, 4, r);
		check(y_window_start_ff === {r[8], r[7:0]}, "y win start");
		check(y_window_end_ff === {r[24], r[23:16]}, "y win end");
		r = $urandom;
		host.send_cmd(CMD_X_COUNTER, 2, r);
		check(ram_address_counter_x_ff === r[5:0], "x counter");
		host.send_cmd(CMD_Y_COUNTER, 2, r);
		check(ram_address_counter_y_ff === {r[8], r[7:0]}, "y counter");
		host.send_cmd(CMD_WRITE_MONO, 0, 32'h0000_0000);
		check(mem_seq_active_ff === 1'b1, "sequence open");
		host.send_cmd(CMD_NO_OPERATION, 0, 32'h0000_0000);
		check(mem_seq_active_ff === 1'b0 && ram_address_counter_x_ff === r[5:0], "nop");
		run_fill(CMD_FILL_MONO, 8'hE5, 1'b1);
		r = $urandom;
		p = {r[7], 3'(r[6:4] % 6), r[3], 3'(r[2:0] % 5)};
		run_fill(CMD_FILL_RED, p, 1'b1);
		run_fill(CMD_FILL_RED, 8'h70, 1'b0);
		run_fill(CMD_FILL_MONO, 8'h06, 1'b0);
		complete_run();
	end
endmodule : tb
